// ==== ptc_cfg.svh ====
// register offsets, field positions, reset values and divider counts of the compare timer
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PTC_OFS_MODE 8'h2b
`define PTC_OFS_CTRL 8'h2c
`define PTC_OFS_CMP_LO 8'h2d
`define PTC_OFS_CMP_HI 8'h2e
`define PTC_OFS_CAP_LO 8'h2f
`define PTC_OFS_CAP_HI 8'h30

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PTC_CTRL_RUN 0
`define PTC_CTRL_DBUF 1
`define PTC_CTRL_OVFIE 2
`define PTC_CTRL_ACAP 3

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define PTC_MODE_OP_LSB 0
`define PTC_MODE_OP_MSB 2
`define PTC_MODE_CK_LSB 3
`define PTC_MODE_CK_MSB 4
`define PTC_MODE_EDGE 5
`define PTC_MODE_RETRIG 6

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define PTC_OP_TIMER0 3'h0
`define PTC_OP_TIMER1 3'h1
`define PTC_OP_EVENT 3'h2
`define PTC_OP_EXTTRIG 3'h4
`define PTC_OP_WINDOW 3'h5

// ----------------------------------------
// reset values
// ----------------------------------------
`define PTC_RST_CMP 16'hffff
`define PTC_RST_CAP 16'hffff
`define PTC_RST_BYTE 8'h00

// ----------------------------------------
// source clock dividers, as prescaler bit counts
// ----------------------------------------
`define PTC_PRE_W 10
`define PTC_DIV_CK0 10
`define PTC_DIV_CK1 6
`define PTC_DIV_CK2 2
`define PTC_DIV_CK3 1

`endif

// ==== ptc_pin_src.sv ====
// pin source standing in for the external pulse or event generator
`timescale 1ns/1ps
`default_nettype none
module ptc_pin_src #(
	parameter int HALF = 3
) (
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic lvl_i,
	output logic pin_o
);
	int cnt;
	// ----
	// toggle every HALF cycles, HALF >= 2 keeps each level at least two cycles
	// ----
	always_ff @(posedge clk_i) begin
		cnt <= en_i ? cnt + 1 : 0;
		if (!en_i) begin
			pin_o <= lvl_i;
		end else if (cnt + 1 >= HALF) begin
			cnt <= 0;
			pin_o <= !pin_o;
		end
	end
endmodule
`default_nettype wire

// ==== ptc_pkg.sv ====
// types of the compare timer
`include "ptc_cfg.svh"

package ptc_pkg;

	typedef enum logic [1:0] {
		PTC_ST_WAIT = 2'b01,
		PTC_ST_COUNT = 2'b10
	} ptc_trig_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] cmp_act;
		logic [15:0] cmp_dbuf;
		logic [7:0] stage;
		logic [15:0] cap;
		logic run;
		logic dbuf_en;
		logic ovf_ie;
		logic acap_en;
		logic [2:0] op_mode;
		logic [1:0] clk_sel;
		logic edge_sel;
		logic retrig;
		ptc_trig_t trig;
		logic [`PTC_PRE_W-1:0] pre;
		logic pin_s1;
		logic pin_s2;
		logic pin_s3;
		logic irq;
		logic [7:0] rdata;
	} ptc_state_t;

endpackage

// ==== ptc_timer.sv ====
// sixteen-bit compare timer with buffered compare register and pin-driven modes
//
// Function
// - low byte write of compare always lands in an 8-bit staging byte
// - high byte write moves high byte and staged low byte together
// - double buffering follows the double-buffer enable bit in control
// - buffered and running: write only buffer; match fires irq and loads buffer in the same cycle
// - buffered: compare reads return last written buffer value
// - buffered and stopped: write loads buffer and active compare together
// - unbuffered: write takes effect at once, running or stopped
// - unbuffered value below count matches only after counter wraps
// - mode 100 is external trigger; edge bit 0 rising, 1 falling
// - triggered mode counts source clock after trigger edge; match irq and clear
// - retrigger-stop set: opposite edge stops and clears, next edge restarts
// - retrigger-stop clear: both edges ignored while counting, which goes on past each match
// - clearing run stops the counter and clears it to zero
// - while running, writes to mode and overflow enable are ignored
// - mode 010 is event counting; edge bit selects rising or falling
// - event mode counts each selected edge; match irq, clear, continue
// - mode 101 is window; edge bit 0 counts while high, 1 while low
// - window mode counts gated source clock; match irq, clear, restart
// - counter is sixteen bits and advances only while run is set
// - auto capture: low byte read latches whole count, high byte gives upper half
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"

module ptc_timer
	import ptc_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic TIMER_INPUT_PIN_I,
	output logic [7:0] RDATA_O,
	output logic TIMER_IRQ_O
);

	ptc_state_t s_reg;
	ptc_state_t s_next;

	// ----------------------------------------
	// decode and pin conditioning
	// ----------------------------------------
	logic wr_mode, wr_ctrl, wr_cmp_lo, wr_cmp_hi, wr_cap_lo, wr_cap_hi;
	logic rd_cap_lo;
	logic rise, fall, sel_edge, opp_edge, win_level;
	logic tick, advance, match;
	logic [15:0] hi_word;

	always_comb begin
		wr_mode = WR_I && (ADDR_I == `PTC_OFS_MODE);
		wr_ctrl = WR_I && (ADDR_I == `PTC_OFS_CTRL);
		wr_cmp_lo = WR_I && (ADDR_I == `PTC_OFS_CMP_LO);
		wr_cmp_hi = WR_I && (ADDR_I == `PTC_OFS_CMP_HI);
		wr_cap_lo = WR_I && (ADDR_I == `PTC_OFS_CAP_LO);
		wr_cap_hi = WR_I && (ADDR_I == `PTC_OFS_CAP_HI);
		rd_cap_lo = RD_I && (ADDR_I == `PTC_OFS_CAP_LO);
		hi_word = {WDATA_I, s_reg.stage};
		// only the second and third stages are looked at
		rise = s_reg.pin_s2 && !s_reg.pin_s3;
		fall = !s_reg.pin_s2 && s_reg.pin_s3;
		sel_edge = s_reg.edge_sel ? fall : rise;
		opp_edge = s_reg.edge_sel ? rise : fall;
		win_level = s_reg.edge_sel ? !s_reg.pin_s2 : s_reg.pin_s2;
	end

	// ----------------------------------------
	// source clock selection
	// ----------------------------------------
	always_comb begin
		unique case (s_reg.clk_sel)
			2'h0: tick = &s_reg.pre[`PTC_DIV_CK0-1:0];
			2'h1: tick = &s_reg.pre[`PTC_DIV_CK1-1:0];
			2'h2: tick = &s_reg.pre[`PTC_DIV_CK2-1:0];
			2'h3: tick = &s_reg.pre[`PTC_DIV_CK3-1:0];
		endcase
	end

	// ----------------------------------------
	// count enable per mode
	// ----------------------------------------
	always_comb begin
		advance = 1'b0;
		if (s_reg.run) begin
			unique case (s_reg.op_mode)
				`PTC_OP_TIMER0, `PTC_OP_TIMER1: advance = tick;
				`PTC_OP_EVENT: advance = sel_edge;
				`PTC_OP_EXTTRIG: advance = tick && (s_reg.trig == PTC_ST_COUNT);
				`PTC_OP_WINDOW: advance = tick && win_level;
				default: advance = 1'b0;
			endcase
		end
		// equality only, so a compare below the count waits for the wrap
		match = advance && (s_reg.cnt == s_reg.cmp_act);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.irq = 1'b0;
		s_next.pre = s_reg.pre + `PTC_PRE_W'(1);
		s_next.pin_s1 = TIMER_INPUT_PIN_I;
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.pin_s3 = s_reg.pin_s2;

		// counter
		if (match) begin
			s_next.irq = 1'b1;
			s_next.cnt = 16'h0000;
			if (s_reg.dbuf_en) begin
				s_next.cmp_act = s_reg.cmp_dbuf;
			end
		end else if (advance) begin
			s_next.cnt = s_reg.cnt + 16'h0001;
		end

		// external trigger sequencing
		if (s_reg.run && (s_reg.op_mode == `PTC_OP_EXTTRIG)) begin
			unique case (s_reg.trig)
				PTC_ST_WAIT: begin
					if (sel_edge) begin
						s_next.trig = PTC_ST_COUNT;
					end
				end
				PTC_ST_COUNT: begin
					// without retrigger-stop edges are simply not looked at
					if (s_reg.retrig && opp_edge) begin
						s_next.trig = PTC_ST_WAIT;
						s_next.cnt = 16'h0000;
					end
				end
			endcase
		end else begin
			s_next.trig = PTC_ST_WAIT;
		end

		// software access: mode and control
		if (wr_mode && !s_reg.run) begin
			s_next.op_mode = WDATA_I[`PTC_MODE_OP_MSB:`PTC_MODE_OP_LSB];
			s_next.clk_sel = WDATA_I[`PTC_MODE_CK_MSB:`PTC_MODE_CK_LSB];
			s_next.edge_sel = WDATA_I[`PTC_MODE_EDGE];
			s_next.retrig = WDATA_I[`PTC_MODE_RETRIG];
		end
		if (wr_ctrl) begin
			s_next.run = WDATA_I[`PTC_CTRL_RUN];
			s_next.dbuf_en = WDATA_I[`PTC_CTRL_DBUF];
			if (!s_reg.run) begin
				s_next.ovf_ie = WDATA_I[`PTC_CTRL_OVFIE];
			end
			// acap cannot change in the same write that stops the timer
			if (!(s_reg.run && !WDATA_I[`PTC_CTRL_RUN])) begin
				s_next.acap_en = WDATA_I[`PTC_CTRL_ACAP];
			end
			if (!WDATA_I[`PTC_CTRL_RUN]) begin
				s_next.cnt = 16'h0000;
				s_next.trig = PTC_ST_WAIT;
			end
		end

		// compare register with staging and double buffer
		if (wr_cmp_lo || wr_cap_lo) begin
			s_next.stage = WDATA_I;
		end
		if (wr_cmp_hi) begin
			s_next.cmp_dbuf = hi_word;
			if (!(s_reg.dbuf_en && s_reg.run)) begin
				s_next.cmp_act = hi_word;
			end
		end
		if (wr_cap_hi) begin
			s_next.cap = hi_word;
		end

		// read path, data valid the cycle after the strobe
		s_next.rdata = 8'h00;
		if (RD_I) begin
			unique case (ADDR_I)
				`PTC_OFS_MODE: s_next.rdata = {1'b0, s_reg.retrig, s_reg.edge_sel,
					s_reg.clk_sel, s_reg.op_mode};
				`PTC_OFS_CTRL: s_next.rdata = {4'h0, s_reg.acap_en, s_reg.ovf_ie,
					s_reg.dbuf_en, s_reg.run};
				`PTC_OFS_CMP_LO: s_next.rdata = s_reg.dbuf_en ?
					s_reg.cmp_dbuf[7:0] : s_reg.cmp_act[7:0];
				`PTC_OFS_CMP_HI: s_next.rdata = s_reg.dbuf_en ?
					s_reg.cmp_dbuf[15:8] : s_reg.cmp_act[15:8];
				`PTC_OFS_CAP_LO: s_next.rdata = (s_reg.acap_en && s_reg.run) ?
					s_reg.cnt[7:0] : (s_reg.acap_en ? 8'h00 : s_reg.cap[7:0]);
				`PTC_OFS_CAP_HI: s_next.rdata = s_reg.cap[15:8];
				default: s_next.rdata = 8'h00;
			endcase
		end
		if (rd_cap_lo && s_reg.acap_en) begin
			// stopped counter reads zero, so both halves capture zero then
			s_next.cap = s_reg.run ? s_reg.cnt : 16'h0000;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s_reg.cnt <= 16'h0000;
			s_reg.cmp_act <= `PTC_RST_CMP;
			s_reg.cmp_dbuf <= `PTC_RST_CMP;
			s_reg.stage <= `PTC_RST_BYTE;
			s_reg.cap <= `PTC_RST_CAP;
			s_reg.run <= 1'b0;
			s_reg.dbuf_en <= 1'b0;
			s_reg.ovf_ie <= 1'b0;
			s_reg.acap_en <= 1'b0;
			s_reg.op_mode <= `PTC_OP_TIMER0;
			s_reg.clk_sel <= 2'h0;
			s_reg.edge_sel <= 1'b0;
			s_reg.retrig <= 1'b0;
			s_reg.trig <= PTC_ST_WAIT;
			s_reg.pre <= '0;
			s_reg.pin_s1 <= 1'b0;
			s_reg.pin_s2 <= 1'b0;
			s_reg.pin_s3 <= 1'b0;
			s_reg.irq <= 1'b0;
			s_reg.rdata <= 8'h00;
		end else begin
			s_reg <= s_next;
		end
	end

	assign RDATA_O = s_reg.rdata;
	assign TIMER_IRQ_O = s_reg.irq;

endmodule
`default_nettype wire

// ==== ptc_timer_chk.sv ====
// port checks of the compare timer
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"
module ptc_timer_chk (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic TIMER_IRQ_O
);
	logic run_q;
	logic dbuf_q;
	logic [6:0] mode_q;
	wire logic wc = WR_I && ADDR_I == `PTC_OFS_CTRL;
	// ----
	// shadow of run, buffer enable and mode, as software last set them
	// ----
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			{dbuf_q, run_q} <= 2'h0;
			mode_q <= 7'h00;
		end else begin
			if (wc) begin
				{dbuf_q, run_q} <= WDATA_I[1:0];
			end
			if (WR_I && ADDR_I == `PTC_OFS_MODE && !run_q) begin
				mode_q <= WDATA_I[6:0];
			end
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	chk_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data outside read slot");
	chk_low_stage: assert property (WR_I && ADDR_I == `PTC_OFS_CMP_LO ##1
		WR_I && ADDR_I == `PTC_OFS_CMP_HI ##1 RD_I ##1 RD_I && ADDR_I == `PTC_OFS_CMP_LO
		|=> RDATA_O == $past(WDATA_I, 4)) else $error("staged low byte lost");
	chk_high_pair: assert property (WR_I && ADDR_I == `PTC_OFS_CMP_HI ##1
		RD_I && ADDR_I == `PTC_OFS_CMP_HI |=> RDATA_O == $past(WDATA_I, 2))
		else $error("high byte not stored");
	chk_irq_pulse: assert property (TIMER_IRQ_O |=> !TIMER_IRQ_O)
		else $error("interrupt longer than one cycle");
	chk_run_gate: assert property (!run_q [*4] |-> !TIMER_IRQ_O)
		else $error("interrupt while stopped");
	chk_stop_quiet: assert property (wc && !WDATA_I[0] |-> ##3 !TIMER_IRQ_O [*4])
		else $error("interrupt after stop");
	chk_mode_lock: assert property (RD_I && ADDR_I == `PTC_OFS_MODE |=>
		RDATA_O[6:0] == mode_q) else $error("mode changed while running");
	chk_ctrl_read: assert property (RD_I && ADDR_I == `PTC_OFS_CTRL |=>
		RDATA_O[1:0] == {dbuf_q, run_q}) else $error("control bits wrong");
endmodule
bind ptc_timer ptc_timer_chk chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TIMER_IRQ_O(TIMER_IRQ_O));
`default_nettype wire

// ==== ptc_timer_tb_top.sv ====
// self-checking bench of the compare timer
`timescale 1ns/1ps
`default_nettype none
`include "ptc_cfg.svh"
module ptc_timer_tb_top;
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic [7:0] ADDR_I = 8'h00;
	logic [7:0] WDATA_I = 8'h00;
	logic [7:0] RDATA_O, n, k;
	logic TIMER_IRQ_O, pin;
	logic en = 1'b0;
	logic lvl = 1'b0;
	logic rd_d = 1'b0;
	logic [15:0] g;
	logic [7:0] q[$];
	int fails = 0;
	int total_checks = 0;
	ptc_timer dut (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WR_I(WR_I), .RD_I(RD_I), .TIMER_INPUT_PIN_I(pin), .RDATA_O(RDATA_O),
		.TIMER_IRQ_O(TIMER_IRQ_O));
	// pin is a pure input from the source model, never driven back
	ptc_pin_src src (.clk_i(CLK_I), .en_i(en), .lvl_i(lvl), .pin_o(pin));
	initial begin
		forever #4 CLK_I = ~CLK_I;
	end
	// ----
	// bus cycles and checks
	// ----
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		RD_I <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		WR_I <= 1'b0;
		q.push_back(e);
	endtask
	task automatic quiet(input int c, output logic [15:0] s);
		@(posedge CLK_I);
		{WR_I, RD_I} <= 2'h0;
		s = 16'h0000;
		repeat (c) begin
			@(posedge CLK_I);
			s = s + {15'h0000, TIMER_IRQ_O};
		end
	endtask
	// first interrupt within lim, then cycles to the next one
	task automatic gap(input int lim, output logic [15:0] d);
		int i;
		quiet(0, d);
		for (i = 0; i < lim && TIMER_IRQ_O !== 1'b1; i++) @(posedge CLK_I);
		@(posedge CLK_I);
		for (d = 16'h1; d < 16'd600 && TIMER_IRQ_O !== 1'b1; d++) @(posedge CLK_I);
		if (i >= lim || d >= 16'd600) begin
			fails++;
			finish_test();
		end
	endtask
	// read data stand one cycle after the strobe
	always @(posedge CLK_I) begin
		rd_d <= RD_I;
		if (rd_d) begin
			chk("read data", {8'h00, q.pop_front()}, {8'h00, RDATA_O});
		end
	end
	initial begin
		void'($urandom(32'hdb91e834));
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(`PTC_OFS_CMP_HI, 8'hff);
		rd(8'h40, 8'h00);
		n = 8'h04 + 8'($urandom % 8);
		k = n + 8'h14;
		wr(`PTC_OFS_MODE, 8'h18);
		wr(`PTC_OFS_CMP_LO, n);
		wr(`PTC_OFS_CMP_HI, 8'h00);
		rd(`PTC_OFS_CMP_HI, 8'h00);
		rd(`PTC_OFS_CMP_LO, n);
		wr(`PTC_OFS_CTRL, 8'h01);
		wr(`PTC_OFS_MODE, 8'h00);
		rd(`PTC_OFS_MODE, 8'h18);
		rd(`PTC_OFS_CTRL, 8'h01);
		gap(200, g);
		chk("timer period", {7'h00, n, 1'b0} + 16'h2, g);
		wr(`PTC_OFS_CTRL, 8'h00);
		quiet(100, g);
		chk("stopped irqs", 16'h0, g);
		wr(`PTC_OFS_CTRL, 8'h03);
		wr(`PTC_OFS_CMP_LO, k);
		wr(`PTC_OFS_CMP_HI, 8'h00);
		rd(`PTC_OFS_CMP_HI, 8'h00);
		rd(`PTC_OFS_CMP_LO, k);
		gap(2 * n + 6, g);
		chk("buffered period", {7'h00, k, 1'b0} + 16'h2, g);
		wr(`PTC_OFS_CTRL, 8'h01);
		wr(`PTC_OFS_CMP_LO, 8'hc8);
		wr(`PTC_OFS_CMP_HI, 8'h00);
		quiet(250, g);
		wr(`PTC_OFS_CMP_LO, 8'h05);
		wr(`PTC_OFS_CMP_HI, 8'h00);
		quiet(1000, g);
		chk("below count", 16'h0, g);
		wr(`PTC_OFS_CMP_LO, 8'h03);
		wr(`PTC_OFS_CMP_HI, 8'h00);
		for (int e = 0; e < 2; e++) begin
			wr(`PTC_OFS_CTRL, 8'h00);
			wr(`PTC_OFS_MODE, {2'h0, e[0], 5'h02});
			wr(`PTC_OFS_CTRL, 8'h01);
			en <= 1'b1;
			gap(60, g);
			chk("event period", 16'h18, g);
			en <= 1'b0;
			// slow level changes only
			lvl <= e[0];
			wr(`PTC_OFS_CTRL, 8'h00);
			wr(`PTC_OFS_MODE, e[0] ? 8'h3d : 8'h1d);
			wr(`PTC_OFS_CTRL, 8'h01);
			quiet(100, g);
			chk("window shut", 16'h0, g);
			lvl <= !e[0];
			gap(40, g);
			chk("window period", 16'h8, g);
		end
		for (int r = 0; r < 2; r++) begin
			lvl <= 1'b0;
			wr(`PTC_OFS_CTRL, 8'h00);
			wr(`PTC_OFS_MODE, {1'b0, r[0], 6'h1c});
			wr(`PTC_OFS_CTRL, 8'h01);
			quiet(50, g);
			chk("trigger wait", 16'h0, g);
			lvl <= 1'b1;
			gap(40, g);
			chk("trigger period", 16'h8, g);
			lvl <= 1'b0;
			repeat (8) @(posedge CLK_I);
			quiet(48, g);
			chk("opposite edge", r[0] ? 16'h0 : 16'h6, g);
		end
		// stop first: capture enable cannot change in the stopping write
		wr(`PTC_OFS_CTRL, 8'h00);
		wr(`PTC_OFS_CTRL, 8'h08);
		rd(`PTC_OFS_CAP_HI, 8'hff);
		rd(`PTC_OFS_CAP_LO, 8'h00);
		rd(`PTC_OFS_CAP_HI, 8'h00);
		quiet(4, g);
		finish_test();
	end
endmodule
`default_nettype wire
